// File: core/dmm_defs.vh
// constants for the two-channel direct memory mover
`ifndef DMM_DEFS_VH
`define DMM_DEFS_VH
`define DMM_NCH 2
`define DMM_AW 16
`define DMM_DW 8
`define DMM_FIFO_DEPTH 16
`define DMM_FIFO_AW 4
`define DMM_NVM_BASE 16'h1000
`define DMM_NVM_LAST 16'h17ff
`define DMM_AM_FIXED 2'h0
`define DMM_AM_INC 2'h1
`define DMM_AM_DEC 2'h2
`define DMM_RL_NONE 2'h0
`define DMM_RL_BURST 2'h1
`define DMM_RL_BLOCK 2'h2
`define DMM_RL_TRANS 2'h3
`define DMM_TS_SW 2'h0
`define DMM_TS_PER 2'h1
`define DMM_TS_EVT 2'h2
`define DMM_BLK_RST 17'h00000
`define DMM_RPT_RST 9'h000
`define DMM_RPT_FULL 9'h100
`endif

// File: core/dmm_direct_memory_mover.v
// two-channel direct memory mover with its byte fifo
//
// Behaviour
// - two channels, each with own trigger select, interrupt lines and address modes
// - each channel keeps own source, destination, trigger and size settings
// - bursts of 1, 2, 4 or 8 bytes, length chosen per channel
// - bursts form a block of 1 byte up to 64KB
// - per-channel repeat counter reruns the block, up to 16MB per transaction
// - source and destination each fixed, incrementing or decrementing per byte
// - optional address restore after each burst, block or transaction
// - channel runs when its selected software, peripheral or event trigger fires
// - per-channel interrupt on transaction end and on detected error
// - linked channels hand over to each other on completion
// - any memory or peripheral pair, including the mapped nonvolatile area
// - moved bytes optionally fed to the checksum generator
// - static ram reads one byte per cycle, nonvolatile area every second cycle
// - read side and write side are separate bus masters
`timescale 1ns/100ps
`default_nettype none
`include "dmm_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module dmm_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk,
   input wire rst,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data,
   output wire [AW:0] count
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wp_q, rp_q;
   reg [AW:0] cnt_q;
   wire push, pop;

   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = mem_q[rp_q];
   assign count = cnt_q;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_q <= {AW{1'b0}};
         rp_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module dmm_direct_memory_mover (
   input wire CLK,
   input wire RST,
   input wire [1:0] START,
   input wire [31:0] SRC_ADDR,
   input wire [31:0] DST_ADDR,
   input wire [31:0] BLOCK_SIZE,
   input wire [15:0] REPEAT_CNT,
   input wire [3:0] BURST_LEN,
   input wire [3:0] SRC_MODE,
   input wire [3:0] DST_MODE,
   input wire [3:0] SRC_RELOAD,
   input wire [3:0] DST_RELOAD,
   input wire [3:0] TRIG_SEL,
   input wire [1:0] SW_TRIG,
   input wire [1:0] PER_REQ,
   input wire [1:0] EVT_TRIG,
   input wire [1:0] TRN_IE,
   input wire [1:0] ERR_IE,
   input wire LINK_EN,
   input wire PRIO_RR,
   input wire CRC_EN,
   output wire [1:0] BUSY,
   output reg [1:0] TRN_IRQ,
   output reg [1:0] ERR_IRQ,
   output wire RD_REQ,
   output wire [15:0] RD_ADDR,
   input wire RD_ACK,
   input wire RD_VALID,
   input wire [7:0] RD_DATA,
   input wire RD_ERR,
   output wire WR_REQ,
   output wire [15:0] WR_ADDR,
   output wire [7:0] WR_DATA,
   input wire WR_ACK,
   input wire WR_ERR,
   output reg CRC_VALID,
   output reg [7:0] CRC_DATA
);
   localparam S_IDLE = 2'h0;
   localparam S_RUN = 2'h1;
   localparam S_END = 2'h2;

   reg [1:0] st_q;
   reg eng_ch_q, last_q, err_q, nvm_wait_q;
   reg [15:0] rd_addr_q, wr_addr_q;
   reg [3:0] rd_left_q, wr_left_q, burst_n_q;
   reg [4:0] out_q;

   wire [1:0] req, done_v, fail_v, cur_sm, cur_dm;
   wire [31:0] src_v, dst_v;
   wire [33:0] blk_v;
   wire [15:0] g_src, g_dst;
   wire [16:0] g_blk;
   wire [3:0] g_blen, g_n;
   wire [4:0] fifo_cnt;
   wire grant_ch, rd_in_nvm, rd_fire, wr_fire, fifo_in_ready, fifo_out_valid, bus_err;

   function [15:0] step;
      input [15:0] a;
      input [1:0] m;
      begin
         case (m)
            `DMM_AM_INC: step = a + 16'h0001;
            `DMM_AM_DEC: step = a - 16'h0001;
            default: step = a;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // per-channel context; the engine only borrows it for one burst
   genvar i;
   generate
      for (i = 0; i < `DMM_NCH; i = i + 1) begin : g_ch
         reg act_q;
         reg pend_q;
         reg [15:0] src_q;
         reg [15:0] dst_q;
         reg [15:0] srcb_q;
         reg [15:0] dstb_q;
         reg [16:0] blk_q;
         reg [8:0] rpt_q;
         reg trig;
         wire mine;
         wire start;
         wire [1:0] srl;
         wire [1:0] drl;
         wire [16:0] blk_left;
         wire blk_end;
         wire trn_end;

         assign mine = (st_q == S_END) & (eng_ch_q == i);
         // handover from the partner when it completes
         assign start = START[i] | (LINK_EN & done_v[1-i]);
         assign srl = SRC_RELOAD[2*i+:2];
         assign drl = DST_RELOAD[2*i+:2];
         assign blk_left = blk_q - {13'h0000, burst_n_q};
         assign blk_end = (blk_left == 17'h00000);
         assign trn_end = blk_end & (rpt_q == 9'h001);

         always @* begin
            case (TRIG_SEL[2*i+:2])
               `DMM_TS_SW: trig = SW_TRIG[i];
               `DMM_TS_PER: trig = PER_REQ[i];
               `DMM_TS_EVT: trig = EVT_TRIG[i];
               default: trig = 1'b0;
            endcase
         end

         assign req[i] = act_q & pend_q;
         assign src_v[16*i+:16] = src_q;
         assign dst_v[16*i+:16] = dst_q;
         assign blk_v[17*i+:17] = blk_q;
         assign done_v[i] = mine & ~err_q & trn_end;
         assign fail_v[i] = mine & err_q;

         always @(posedge CLK or posedge RST) begin
            if (RST) begin
               act_q <= 1'b0;
               pend_q <= 1'b0;
               src_q <= 16'h0000;
               dst_q <= 16'h0000;
               srcb_q <= 16'h0000;
               dstb_q <= 16'h0000;
               blk_q <= `DMM_BLK_RST;
               rpt_q <= `DMM_RPT_RST;
            end else if (start) begin
               act_q <= 1'b1;
               pend_q <= 1'b0;
               src_q <= SRC_ADDR[16*i+:16];
               dst_q <= DST_ADDR[16*i+:16];
               srcb_q <= SRC_ADDR[16*i+:16];
               dstb_q <= DST_ADDR[16*i+:16];
               // a size of zero stands for the full 64KB block
               blk_q <= {(BLOCK_SIZE[16*i+:16] == 16'h0000), BLOCK_SIZE[16*i+:16]};
               // a repeat of zero stands for 256 blocks, reaching 16MB
               rpt_q <= (REPEAT_CNT[8*i+:8] == 8'h00) ? `DMM_RPT_FULL
                        : {1'b0, REPEAT_CNT[8*i+:8]};
            end else if (mine) begin
               if (err_q) begin
                  act_q <= 1'b0;
                  pend_q <= 1'b0;
               end else begin
                  src_q <= ((srl == `DMM_RL_BURST) | (blk_end & (srl == `DMM_RL_BLOCK))
                           | (trn_end & (srl == `DMM_RL_TRANS))) ? srcb_q : rd_addr_q;
                  dst_q <= ((drl == `DMM_RL_BURST) | (blk_end & (drl == `DMM_RL_BLOCK))
                           | (trn_end & (drl == `DMM_RL_TRANS))) ? dstb_q : wr_addr_q;
                  if (blk_end) begin
                     blk_q <= {(BLOCK_SIZE[16*i+:16] == 16'h0000), BLOCK_SIZE[16*i+:16]};
                     rpt_q <= rpt_q - 9'h001;
                     act_q <= ~trn_end;
                     // software trigger runs the whole transaction, others one block
                     pend_q <= trig | ((TRIG_SEL[2*i+:2] == `DMM_TS_SW) & ~trn_end);
                  end else begin
                     blk_q <= blk_left;
                     pend_q <= 1'b1;
                  end
               end
            end else if (trig & act_q) begin
               pend_q <= 1'b1;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // arbitration only in idle, which is only reached between bursts
   assign grant_ch = (req == 2'b11) ? (PRIO_RR ? ~last_q : 1'b0) : req[1];
   assign g_src = grant_ch ? src_v[31:16] : src_v[15:0];
   assign g_dst = grant_ch ? dst_v[31:16] : dst_v[15:0];
   assign g_blk = grant_ch ? blk_v[33:17] : blk_v[16:0];
   assign g_blen = 4'h1 << (grant_ch ? BURST_LEN[3:2] : BURST_LEN[1:0]);
   // a short tail of the block shortens the last burst
   assign g_n = (g_blk < {13'h0000, g_blen}) ? g_blk[3:0] : g_blen;
   assign cur_sm = eng_ch_q ? SRC_MODE[3:2] : SRC_MODE[1:0];
   assign cur_dm = eng_ch_q ? DST_MODE[3:2] : DST_MODE[1:0];

   // nonvolatile area answers at half rate, so reads there are spaced
   assign rd_in_nvm = (rd_addr_q >= `DMM_NVM_BASE) & (rd_addr_q <= `DMM_NVM_LAST);
   // credit check keeps every outstanding read a guaranteed fifo slot
   assign RD_REQ = (st_q == S_RUN) & (rd_left_q != 4'h0) & fifo_in_ready & ~nvm_wait_q
                   & ({1'b0, fifo_cnt} + {1'b0, out_q} < `DMM_FIFO_DEPTH);
   assign RD_ADDR = rd_addr_q;
   assign rd_fire = RD_REQ & RD_ACK;
   // write side drains independently of the read side
   assign WR_REQ = (st_q == S_RUN) & fifo_out_valid;
   assign WR_ADDR = wr_addr_q;
   assign wr_fire = WR_REQ & WR_ACK;
   assign bus_err = (st_q == S_RUN) & ((RD_VALID & RD_ERR) | (wr_fire & WR_ERR));
   assign BUSY = {g_ch[1].act_q, g_ch[0].act_q};

   dmm_fifo #(
      .WIDTH(`DMM_DW),
      .DEPTH(`DMM_FIFO_DEPTH),
      .AW(`DMM_FIFO_AW)
   ) u_fifo (
      .clk(CLK),
      .rst(RST),
      .in_valid(RD_VALID),
      .in_ready(fifo_in_ready),
      .in_data(RD_DATA),
      .out_valid(fifo_out_valid),
      .out_ready(wr_fire),
      .out_data(WR_DATA),
      .count(fifo_cnt)
   );

   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         st_q <= S_IDLE;
         eng_ch_q <= 1'b0;
         last_q <= 1'b1;
         err_q <= 1'b0;
         nvm_wait_q <= 1'b0;
         rd_addr_q <= 16'h0000;
         wr_addr_q <= 16'h0000;
         rd_left_q <= 4'h0;
         wr_left_q <= 4'h0;
         burst_n_q <= 4'h0;
         out_q <= 5'h00;
      end else begin
         case (st_q)
            S_IDLE: begin
               if (req != 2'b00) begin
                  eng_ch_q <= grant_ch;
                  rd_addr_q <= g_src;
                  wr_addr_q <= g_dst;
                  rd_left_q <= g_n;
                  wr_left_q <= g_n;
                  burst_n_q <= g_n;
                  err_q <= 1'b0;
                  st_q <= S_RUN;
               end
            end
            S_RUN: begin
               nvm_wait_q <= rd_fire & rd_in_nvm;
               if (rd_fire) begin
                  rd_addr_q <= step(rd_addr_q, cur_sm);
                  rd_left_q <= rd_left_q - 4'h1;
               end
               if (rd_fire & ~RD_VALID) begin
                  out_q <= out_q + 5'h01;
               end else if (RD_VALID & ~rd_fire) begin
                  out_q <= out_q - 5'h01;
               end
               if (bus_err) begin
                  err_q <= 1'b1;
               end
               if (wr_fire) begin
                  wr_addr_q <= step(wr_addr_q, cur_dm);
                  wr_left_q <= wr_left_q - 4'h1;
                  // the burst owns the engine until its last byte is written
                  if (wr_left_q == 4'h1) begin
                     st_q <= S_END;
                  end
               end
            end
            S_END: begin
               last_q <= eng_ch_q;
               st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt pulses and checksum feed are registered
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         TRN_IRQ <= 2'b00;
         ERR_IRQ <= 2'b00;
         CRC_VALID <= 1'b0;
         CRC_DATA <= 8'h00;
      end else begin
         TRN_IRQ <= done_v & TRN_IE;
         ERR_IRQ <= fail_v & ERR_IE;
         CRC_VALID <= wr_fire & CRC_EN;
         if (wr_fire & CRC_EN) begin
            CRC_DATA <= WR_DATA;
         end
      end
   end
endmodule
`default_nettype wire

// File: test/dmm_mem_model.sv
// data memory and peripheral bus model facing the mover
`timescale 1ns/100ps
`default_nettype none
module dmm_mem_model (
   input wire CLK,
   input wire RD_REQ,
   input wire [15:0] RD_ADDR,
   output logic RD_ACK,
   output logic RD_VALID,
   output logic [7:0] RD_DATA,
   output logic RD_ERR,
   input wire WR_REQ,
   input wire [15:0] WR_ADDR,
   input wire [7:0] WR_DATA,
   output logic WR_ACK,
   output logic WR_ERR,
   input wire slow,
   input wire rerr,
   input wire [15:0] eaddr
);
   logic ph = 1'b0;
   logic [7:0] last = 8'h00;
   logic [7:0] wm [0:65535];
   int wcnt = 0;
   // slow mode stalls each side on alternate cycles
   assign RD_ACK = RD_REQ && !(slow && ph);
   assign WR_ACK = WR_REQ && !(slow && !ph);
   assign WR_ERR = 1'b0;
   // released data line shows the inverse, not a stale byte
   assign RD_DATA = RD_VALID ? last : ~last;
   always @(posedge CLK) begin
      ph <= !ph;
      RD_VALID <= RD_ACK;
      RD_ERR <= RD_ACK && rerr && RD_ADDR == eaddr;
      if (RD_ACK) begin
         last <= RD_ADDR[7:0] ^ RD_ADDR[15:8] ^ (RD_ADDR[15:11] == 5'h02 ? 8'h3c : 8'h00);
      end
      if (WR_ACK) begin
         wm[WR_ADDR] <= WR_DATA;
         wcnt <= wcnt + 1;
      end
   end
endmodule
`default_nettype wire

// File: test/dmm_props.sv
// port checker for the direct memory mover
`timescale 1ns/100ps
`default_nettype none
module dmm_props (
   input wire CLK,
   input wire RST,
   input wire [1:0] BUSY,
   input wire [1:0] TRN_IRQ,
   input wire [1:0] ERR_IRQ,
   input wire [1:0] TRN_IE,
   input wire [1:0] ERR_IE,
   input wire RD_REQ,
   input wire RD_ACK,
   input wire [15:0] RD_ADDR,
   input wire WR_REQ,
   input wire WR_ACK,
   input wire [7:0] WR_DATA,
   input wire [15:0] WR_ADDR,
   input wire CRC_EN,
   input wire CRC_VALID,
   input wire [7:0] CRC_DATA
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   ////////////////////////////////////////
   a_rd_hold: assert property (RD_REQ && !RD_ACK |=> RD_REQ && $stable(RD_ADDR))
      else $error("read request dropped");
   a_wr_hold: assert property (WR_REQ && !WR_ACK |=> WR_REQ && $stable({WR_ADDR, WR_DATA}))
      else $error("write request dropped");
   // nonvolatile reads give a byte only every second cycle
   a_nvm_gap: assert property (RD_REQ && RD_ACK && RD_ADDR[15:11] == 5'h02 |=> !RD_REQ)
      else $error("nonvolatile read too fast");
   a_irq_pulse: assert property ((TRN_IRQ & $past(TRN_IRQ)) == 2'h0)
      else $error("completion pulse too long");
   a_irq_excl: assert property ((TRN_IRQ & ERR_IRQ) == 2'h0)
      else $error("completion and error together");
   a_irq_gate: assert property (((TRN_IRQ & ~TRN_IE) | (ERR_IRQ & ~ERR_IE)) == 2'h0)
      else $error("masked interrupt raised");
   a_crc_copy: assert property (WR_REQ && WR_ACK && CRC_EN |=>
      CRC_VALID && CRC_DATA == $past(WR_DATA))
      else $error("checksum byte missing");
   a_crc_cause: assert property (CRC_VALID |-> $past(WR_REQ) && $past(WR_ACK))
      else $error("checksum byte without write");
   a_req_armed: assert property (RD_REQ |-> BUSY != 2'h0)
      else $error("read while no channel armed");
   c_done: cover property (TRN_IRQ[0]);
   c_err: cover property (ERR_IRQ[0]);
   c_nvm: cover property (RD_REQ && RD_ACK && RD_ADDR[15:11] == 5'h02);
endmodule
bind dmm_direct_memory_mover dmm_props i_dmm_props (.*);
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench for the direct memory mover
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic ch;
      logic [1:0] bl, sm, dm, sr, dr, ts;
      logic [15:0] blk, sa, da;
      logic [7:0] rpt;
   } row_t;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic [1:0] START = 2'h0, SW_TRIG = 2'h0, PER_REQ = 2'h0, EVT_TRIG = 2'h0;
   logic [1:0] TRN_IE = 2'h3, ERR_IE = 2'h3;
   logic [31:0] SRC_ADDR = 32'h0, DST_ADDR = 32'h0, BLOCK_SIZE = 32'h0;
   logic [15:0] REPEAT_CNT = 16'h0, eaddr = 16'h0;
   logic [3:0] BURST_LEN = 4'h0, SRC_MODE = 4'h0, DST_MODE = 4'h0, TRIG_SEL = 4'hf;
   logic [3:0] SRC_RELOAD = 4'h0, DST_RELOAD = 4'h0;
   logic LINK_EN = 1'b0, PRIO_RR = 1'b0, CRC_EN = 1'b1, slow = 1'b0, rerr = 1'b0;
   wire [1:0] BUSY, TRN_IRQ, ERR_IRQ;
   wire RD_REQ, RD_ACK, RD_VALID, RD_ERR, WR_REQ, WR_ACK, WR_ERR, CRC_VALID;
   wire [15:0] RD_ADDR, WR_ADDR;
   wire [7:0] RD_DATA, WR_DATA, CRC_DATA;
   int n_fail = 0, samples_checked = 0, cyc = 0, n, b, w0, si, di;
   logic t, e;
   row_t r;
   logic [7:0] ex [logic [15:0]];
   // ch, burst, src mode, dst mode, src reload, dst reload, trigger, block, src, dst, repeat
   row_t rows [7] = '{
      '{1'b0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 16'h0003, 16'h0100, 16'h0200, 8'h01},
      '{1'b1, 2'h3, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 16'h0014, 16'h0300, 16'h0450, 8'h02},
      '{1'b0, 2'h2, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 16'h000c, 16'h0500, 16'h0540, 8'h01},
      '{1'b1, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h2, 16'h0006, 16'h0620, 16'h0700, 8'h01},
      '{1'b0, 2'h3, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 16'h0010, 16'h0800, 16'h0880, 8'h02},
      '{1'b1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0, 16'h0008, 16'h0900, 16'h0980, 8'h03},
      '{1'b0, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 16'h000a, 16'h1000, 16'h0a00, 8'h01}};
   dmm_direct_memory_mover i_dmm_direct_memory_mover (.*);
   dmm_mem_model i_mem (.*);
   always #5 CLK = ~CLK;
   ////////////////////////////////////////
   function logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ (a[15:11] == 5'h02 ? 8'h3c : 8'h00);
   endfunction
   function int off(input logic [1:0] m, input int x);
      return m == 2'h1 ? x : (m == 2'h2 ? -x : 0);
   endfunction
   task tick;
      @(posedge CLK);
      #1;
   endtask
   task chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task final_report;
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task go(input row_t q, input logic st);
      int c;
      c = q.ch;
      SRC_ADDR[c*16 +: 16] = q.sa;
      DST_ADDR[c*16 +: 16] = q.da;
      BLOCK_SIZE[c*16 +: 16] = q.blk;
      REPEAT_CNT[c*8 +: 8] = q.rpt;
      BURST_LEN[c*2 +: 2] = q.bl;
      SRC_MODE[c*2 +: 2] = q.sm;
      DST_MODE[c*2 +: 2] = q.dm;
      SRC_RELOAD[c*2 +: 2] = q.sr;
      DST_RELOAD[c*2 +: 2] = q.dr;
      TRIG_SEL[c*2 +: 2] = q.ts;
      START[c] = st;
      tick;
      START = 2'h0;
   endtask
   task trig(input row_t q);
      {EVT_TRIG, PER_REQ, SW_TRIG} = 6'h01 << (q.ts * 2 + q.ch);
      tick;
      {EVT_TRIG, PER_REQ, SW_TRIG} = 6'h00;
   endtask
   task waitirq(input int c);
      t = 1'b0;
      e = 1'b0;
      for (int k = 0; k < 4000 && !(t || e); k++) begin
         tick;
         t = TRN_IRQ[c] === 1'b1;
         e = ERR_IRQ[c] === 1'b1;
      end
      repeat (3) tick;
   endtask
   // cut a hang short well beyond the longest expected run
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 50000) begin
         n_fail++;
         final_report;
      end
   end
   ////////////////////////////////////////
   initial begin
      repeat (5) tick;
      RST = 1'b0;
      chk(BUSY === 2'h0 && RD_REQ === 1'b0, "idle after reset");
      for (int i = 0; i < 7; i++) begin
         r = rows[i];
         slow = i[0];
         w0 = i_mem.wcnt;
         n = r.blk * r.rpt;
         b = 1 << r.bl;
         ex.delete();
         for (int k = 0; k < n; k++) begin
            si = r.sr == 2'h1 ? (k % r.blk) % b : (r.sr == 2'h2 ? k % r.blk : k);
            di = r.dr == 2'h1 ? (k % r.blk) % b : (r.dr == 2'h2 ? k % r.blk : k);
            ex[16'(r.da + off(r.dm, di))] = pat(16'(r.sa + off(r.sm, si)));
         end
         go(r, 1'b1);
         trig(r);
         waitirq(r.ch);
         chk(t === 1'b1 && e === 1'b0 && BUSY[r.ch] === 1'b0, "transaction end");
         chk(i_mem.wcnt - w0 == n, "byte count");
         foreach (ex[a]) chk(i_mem.wm[a] === ex[a], "moved byte");
      end
      // a read error ends the channel without a completion pulse
      rerr = 1'b1;
      eaddr = 16'h0101;
      go(rows[0], 1'b1);
      trig(rows[0]);
      waitirq(0);
      chk(e === 1'b1 && t === 1'b0 && BUSY[0] === 1'b0, "error end");
      rerr = 1'b0;
      w0 = i_mem.wcnt;
      SW_TRIG = 2'h3;
      repeat (10) tick;
      SW_TRIG = 2'h0;
      chk(BUSY === 2'h0 && i_mem.wcnt == w0, "unarmed trigger");
      go(rows[1], 1'b1);
      go(rows[0], 1'b1);
      SW_TRIG = 2'h3;
      tick;
      SW_TRIG = 2'h0;
      for (int k = 0; k < 20 && RD_REQ !== 1'b1; k++) tick;
      chk(RD_ADDR === rows[0].sa, "fixed priority");
      waitirq(1);
      chk(t === 1'b1 && BUSY === 2'h0, "both channels done");
      // ch1 is armed only by the link, its trigger held high meanwhile
      LINK_EN = 1'b1;
      PRIO_RR = 1'b1;
      // ch0 completion masked: hand over must not hang on the enable
      TRN_IE = 2'h2;
      go(rows[1], 1'b0);
      go(rows[0], 1'b1);
      SW_TRIG = 2'h3;
      tick;
      SW_TRIG = 2'h2;
      waitirq(1);
      chk(t === 1'b1 && BUSY === 2'h1, "linked hand over");
      SW_TRIG = 2'h0;
      LINK_EN = 1'b0;
      TRN_IE = 2'h3;
      // ch1 served last: ch0 takes the first tie, ch1 must take the next one
      go(rows[1], 1'b1);
      SW_TRIG = 2'h3;
      tick;
      SW_TRIG = 2'h0;
      for (int k = 0; k < 20 && RD_REQ !== 1'b1; k++) tick;
      tick;
      for (int k = 0; k < 20 && RD_REQ !== 1'b1; k++) tick;
      chk(RD_ADDR === rows[1].sa, "round robin");
      // reset lands while ch1 owns the engine
      w0 = i_mem.wcnt;
      RST = 1'b1;
      tick;
      chk(BUSY === 2'h0 && RD_REQ === 1'b0 && WR_REQ === 1'b0, "reset in run");
      RST = 1'b0;
      repeat (5) tick;
      chk(BUSY === 2'h0 && WR_REQ === 1'b0 && i_mem.wcnt == w0, "quiet after reset");
      final_report;
   end
endmodule
`default_nettype wire
